// ===== gpsw_pkg.sv
package gpsw_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0] GPSW_ADDR_GPIO_PAIR_HI = 8'h1D;
  localparam logic [7:0] GPSW_ADDR_GPIO_PAIR_LO = 8'h1E;
  localparam logic [7:0] GPSW_ADDR_STRAP_OVR = 8'h1F;
  localparam logic [7:0] GPSW_ADDR_WDOG_CTRL = 8'h20;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] GPSW_RST_GPIO_PAIR = 8'h33;
  localparam logic [7:0] GPSW_RST_STRAP_OVR = 8'h00;
  localparam logic [7:0] GPSW_RST_WDOG_CTRL = 8'hFE;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int GPSW_BIT_UP_VAL = 7;
  localparam int GPSW_BIT_UP_DIR = 5;
  localparam int GPSW_BIT_UP_EN = 4;
  localparam int GPSW_BIT_LO_VAL = 3;
  localparam int GPSW_BIT_LO_DIR = 1;
  localparam int GPSW_BIT_LO_EN = 0;
  localparam logic [7:0] GPSW_GPIO_PAIR_MASK = 8'hBB;
  localparam int GPSW_BIT_OVR = 7;
  localparam int GPSW_BIT_OUT_EN = 6;
  localparam int GPSW_BIT_SLEEP_SEL = 5;
  localparam int GPSW_BIT_WDOG_DIS = 0;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int GPSW_CLK_MHZ = 125;
  localparam int GPSW_WDOG_UNIT_MS = 2;
  localparam int GPSW_WDOG_UNIT_CYC = GPSW_WDOG_UNIT_MS * 1000 * GPSW_CLK_MHZ;

  // register write strobe carrier
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } gpsw_reg_wr_t;

  // pin-sampled strap selections
  typedef struct packed {
    logic output_enable_cfg;
    logic output_sleep_state_sel;
  } gpsw_strap_t;

  typedef enum logic [1:0] {
    GPSW_WD_IDLE = 2'b00,
    GPSW_WD_RUN = 2'b01,
    GPSW_WD_ABORT = 2'b11
  } gpsw_wd_state_t;
endpackage

// ===== gpsw_watchdog.sv
`timescale 1ns/1ps
module gpsw_watchdog #(
  parameter int UNIT_CYC = gpsw_pkg::GPSW_WDOG_UNIT_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // configuration
  input wire logic [6:0] i_timeout_units,
  input wire logic i_disable,
  // transaction engine
  input wire logic i_xact_busy,
  output logic o_abort
);
  import gpsw_pkg::*;

  gpsw_wd_state_t state, next_state;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [6:0] unit_cnt, next_unit_cnt;
  logic next_abort;

  // --------------------------------------------------------------
  // timing state machine
  // --------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_unit_cnt = unit_cnt;
    next_abort = 1'b0;
    case (state)
      GPSW_WD_IDLE: begin
        next_tick_cnt = '0;
        next_unit_cnt = '0;
        if (i_xact_busy && !i_disable) begin // [R11]
          next_state = GPSW_WD_RUN;
        end
      end
      GPSW_WD_RUN: begin
        if (!i_xact_busy || i_disable) begin // [R11]
          next_state = GPSW_WD_IDLE;
        end else if (tick_cnt == 32'(UNIT_CYC - 1)) begin
          next_tick_cnt = '0;
          next_unit_cnt = unit_cnt + 7'h01;
          // timeout is field times 2 ms; a zero field aborts after 1 unit
          if (unit_cnt + 7'h01 >= i_timeout_units) begin // [R9]
            next_state = GPSW_WD_ABORT;
            next_abort = 1'b1; // [R8]
          end
        end else begin
          next_tick_cnt = tick_cnt + 32'h1;
        end
      end
      GPSW_WD_ABORT: begin
        // wait for the engine to drop busy so the channel is freed
        if (!i_xact_busy) begin
          next_state = GPSW_WD_IDLE;
        end
      end
      default: next_state = GPSW_WD_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= GPSW_WD_IDLE;
      tick_cnt <= '0;
      unit_cnt <= '0;
      o_abort <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      unit_cnt <= next_unit_cnt;
      o_abort <= next_abort;
    end
  end
endmodule

// ===== gpsw_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] pin drives its value bit only when enabled and set to output
// [R2] direction one means input, zero means output; bits 5 and 1
// [R3] enable zero floats the pin whatever direction and value say
// [R4] 0x1D holds pin 2 in upper nibble, pin 3 lower; 6,2 reserved
// [R5] 0x1E holds pin 0 upper, pin 1 lower, same layout
// [R6] override bit 7 clear uses pin-sampled selections; reset 0x00
// [R7] override set takes output enable bit 6, sleep state bit 5; here bit 5 is read-only and the last pin-sampled sleep state is held
// [R8] watchdog aborts a control transaction that overruns timeout
// [R9] timeout is bits 7:1 times 2 ms; reset value 0xFE
// [R10] software should never program a zero timeout
// [R11] bit 0 set disables the watchdog, clear lets it run
// [R12] both pin-pair registers reset to 0x33
// [R13] reserved bits read zero; sleep-state bit read-only, shows effect
module gpsw_regs #(
  parameter int WDOG_UNIT_CYC = gpsw_pkg::GPSW_WDOG_UNIT_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // register access from the serial control port
  input wire gpsw_pkg::gpsw_reg_wr_t i_reg_wr,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // configuration straps sampled from pins
  input wire gpsw_pkg::gpsw_strap_t i_strap,
  output gpsw_pkg::gpsw_strap_t o_strap_eff,
  // general-purpose pins, index n is gp_pin_n
  input wire logic [3:0] i_gp_pin,
  output logic [3:0] o_gp_pin,
  output logic [3:0] o_gp_pin_oe,
  output logic [3:0] o_gp_pin_in,
  // control channel transaction engine
  input wire logic i_xact_busy,
  output logic o_xact_abort
);
  import gpsw_pkg::*;

  logic [7:0] gpio_pair_hi_config, next_gpio_pair_hi_config;
  logic [7:0] gpio_pair_lo_config, next_gpio_pair_lo_config;
  logic strap_override, next_strap_override;
  logic output_enable_reg, next_output_enable_reg;
  // sleep-state selection held while the override is set
  logic sleep_sel_reg, next_sleep_sel_reg;
  logic [7:0] channel_watchdog_control, next_channel_watchdog_control;
  logic [7:0] next_rd_data;
  logic [3:0] next_gp_pin, next_gp_pin_oe, next_gp_pin_in;
  gpsw_strap_t next_strap_eff;
  logic [7:0] strap_reg_view;

  // drive enable for one pin from its dir/enable bits
  function automatic logic pin_drives(input logic en, input logic dir);
    return en && !dir; // [R2] [R3]
  endfunction

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  always_comb begin
    next_gpio_pair_hi_config = gpio_pair_hi_config;
    next_gpio_pair_lo_config = gpio_pair_lo_config;
    next_strap_override = strap_override;
    next_output_enable_reg = output_enable_reg;
    next_channel_watchdog_control = channel_watchdog_control;
    if (i_reg_wr.wr) begin
      if (i_reg_wr.addr == GPSW_ADDR_GPIO_PAIR_HI) begin
        next_gpio_pair_hi_config =
          i_reg_wr.data & GPSW_GPIO_PAIR_MASK; // [R4] [R13]
      end else if (i_reg_wr.addr == GPSW_ADDR_GPIO_PAIR_LO) begin
        next_gpio_pair_lo_config =
          i_reg_wr.data & GPSW_GPIO_PAIR_MASK; // [R5] [R13]
      end else if (i_reg_wr.addr == GPSW_ADDR_STRAP_OVR) begin
        // sleep-state bit is read-only and takes no write
        next_strap_override = i_reg_wr.data[GPSW_BIT_OVR]; // [R13]
        next_output_enable_reg = i_reg_wr.data[GPSW_BIT_OUT_EN]; // [R7]
      end else if (i_reg_wr.addr == GPSW_ADDR_WDOG_CTRL) begin
        next_channel_watchdog_control = i_reg_wr.data;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gpio_pair_hi_config <= GPSW_RST_GPIO_PAIR; // [R12]
      gpio_pair_lo_config <= GPSW_RST_GPIO_PAIR; // [R12]
      strap_override <= GPSW_RST_STRAP_OVR[GPSW_BIT_OVR]; // [R6]
      output_enable_reg <= GPSW_RST_STRAP_OVR[GPSW_BIT_OUT_EN];
      channel_watchdog_control <= GPSW_RST_WDOG_CTRL; // [R9]
    end else begin
      gpio_pair_hi_config <= next_gpio_pair_hi_config;
      gpio_pair_lo_config <= next_gpio_pair_lo_config;
      strap_override <= next_strap_override;
      output_enable_reg <= next_output_enable_reg;
      channel_watchdog_control <= next_channel_watchdog_control;
    end
  end

  // --------------------------------------------------------------
  // sleep-state select
  // --------------------------------------------------------------
  // no write reaches this bit: it follows the pin while the override
  // is clear and freezes when the override is set, so turning the
  // override on never makes the selection in effect jump
  always_comb begin
    next_sleep_sel_reg = sleep_sel_reg;
    if (!strap_override) begin
      next_sleep_sel_reg = i_strap.output_sleep_state_sel; // [R7] [R13]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_sel_reg <= GPSW_RST_STRAP_OVR[GPSW_BIT_SLEEP_SEL];
    end else begin
      sleep_sel_reg <= next_sleep_sel_reg;
    end
  end

  // --------------------------------------------------------------
  // pins and straps
  // --------------------------------------------------------------
  // a floated or input pin shows 0 on o_gp_pin, so the pad side never
  // sees a stale output value
  always_comb begin
    // index order: pin 0,1 from 0x1E, pin 2,3 from 0x1D
    next_gp_pin_oe[0] = pin_drives(gpio_pair_lo_config[GPSW_BIT_UP_EN],
      gpio_pair_lo_config[GPSW_BIT_UP_DIR]); // [R5]
    next_gp_pin_oe[1] = pin_drives(gpio_pair_lo_config[GPSW_BIT_LO_EN],
      gpio_pair_lo_config[GPSW_BIT_LO_DIR]);
    next_gp_pin_oe[2] = pin_drives(gpio_pair_hi_config[GPSW_BIT_UP_EN],
      gpio_pair_hi_config[GPSW_BIT_UP_DIR]); // [R4]
    next_gp_pin_oe[3] = pin_drives(gpio_pair_hi_config[GPSW_BIT_LO_EN],
      gpio_pair_hi_config[GPSW_BIT_LO_DIR]);
    next_gp_pin[0] = next_gp_pin_oe[0] &&
      gpio_pair_lo_config[GPSW_BIT_UP_VAL]; // [R1]
    next_gp_pin[1] = next_gp_pin_oe[1] &&
      gpio_pair_lo_config[GPSW_BIT_LO_VAL]; // [R1]
    next_gp_pin[2] = next_gp_pin_oe[2] &&
      gpio_pair_hi_config[GPSW_BIT_UP_VAL]; // [R1]
    next_gp_pin[3] = next_gp_pin_oe[3] &&
      gpio_pair_hi_config[GPSW_BIT_LO_VAL]; // [R1]
    // input seen only while the pin is enabled as input
    next_gp_pin_in[0] = gpio_pair_lo_config[GPSW_BIT_UP_EN] &&
      gpio_pair_lo_config[GPSW_BIT_UP_DIR] && i_gp_pin[0];
    next_gp_pin_in[1] = gpio_pair_lo_config[GPSW_BIT_LO_EN] &&
      gpio_pair_lo_config[GPSW_BIT_LO_DIR] && i_gp_pin[1];
    next_gp_pin_in[2] = gpio_pair_hi_config[GPSW_BIT_UP_EN] &&
      gpio_pair_hi_config[GPSW_BIT_UP_DIR] && i_gp_pin[2];
    next_gp_pin_in[3] = gpio_pair_hi_config[GPSW_BIT_LO_EN] &&
      gpio_pair_hi_config[GPSW_BIT_LO_DIR] && i_gp_pin[3];

    if (strap_override) begin
      next_strap_eff.output_enable_cfg = output_enable_reg; // [R7]
      next_strap_eff.output_sleep_state_sel = sleep_sel_reg; // [R7]
    end else begin
      next_strap_eff = i_strap; // [R6]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gp_pin <= 4'h0;
      o_gp_pin_oe <= 4'h0;
      o_gp_pin_in <= 4'h0;
      o_strap_eff <= '0;
    end else begin
      o_gp_pin <= next_gp_pin;
      o_gp_pin_oe <= next_gp_pin_oe;
      o_gp_pin_in <= next_gp_pin_in;
      o_strap_eff <= next_strap_eff;
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  // the sleep-state bit shows the selection in effect rather than a
  // stored copy, so software reads what the output stage is given;
  // the cost is one extra mux level on the read path
  always_comb begin
    strap_reg_view = 8'h00;
    strap_reg_view[GPSW_BIT_OVR] = strap_override;
    strap_reg_view[GPSW_BIT_OUT_EN] = output_enable_reg;
    strap_reg_view[GPSW_BIT_SLEEP_SEL] =
      next_strap_eff.output_sleep_state_sel; // [R13]

    if (i_rd_addr == GPSW_ADDR_GPIO_PAIR_HI) begin
      next_rd_data = gpio_pair_hi_config;
    end else if (i_rd_addr == GPSW_ADDR_GPIO_PAIR_LO) begin
      next_rd_data = gpio_pair_lo_config;
    end else if (i_rd_addr == GPSW_ADDR_STRAP_OVR) begin
      next_rd_data = strap_reg_view;
    end else if (i_rd_addr == GPSW_ADDR_WDOG_CTRL) begin
      next_rd_data = channel_watchdog_control;
    end else begin
      // unmapped offsets read as zero
      next_rd_data = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  // --------------------------------------------------------------
  // control channel watchdog
  // --------------------------------------------------------------
  // the unit length is a parameter so a short unit can stand in for
  // 2 ms in simulation; hardware keeps the default
  gpsw_watchdog #(
    .UNIT_CYC(WDOG_UNIT_CYC)
  ) gpsw_watchdog_i (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_timeout_units(channel_watchdog_control[7:1]), // [R9]
    .i_disable(channel_watchdog_control[GPSW_BIT_WDOG_DIS]), // [R11]
    .i_xact_busy(i_xact_busy),
    .o_abort(o_xact_abort) // [R8]
  );
endmodule

// ===== gpsw_regs_monitor.sv
`timescale 1ns/1ps
module gpsw_regs_monitor
  import gpsw_pkg::*;
#(
  parameter int WDOG_UNIT_CYC = GPSW_WDOG_UNIT_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // register access
  input wire gpsw_pkg::gpsw_reg_wr_t i_reg_wr,
  input wire logic [7:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  // straps and pins
  input wire gpsw_pkg::gpsw_strap_t i_strap,
  input wire gpsw_pkg::gpsw_strap_t o_strap_eff,
  input wire logic [3:0] i_gp_pin,
  input wire logic [3:0] o_gp_pin,
  input wire logic [3:0] o_gp_pin_oe,
  input wire logic [3:0] o_gp_pin_in,
  // transaction engine
  input wire logic i_xact_busy,
  input wire logic o_xact_abort
);
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  logic ovr_seen;
  logic next_ovr_seen;
  wire lo_wr = i_reg_wr.wr && i_reg_wr.addr == GPSW_ADDR_GPIO_PAIR_LO;
  wire pair_rd = i_rd_addr == GPSW_ADDR_GPIO_PAIR_HI ||
                 i_rd_addr == GPSW_ADDR_GPIO_PAIR_LO;
  // --------------------------------------------------------------
  // consecutive busy cycles and the override bit as last written
  // --------------------------------------------------------------
  // 32 bits so a full 2 ms unit is counted without wrapping
  always_comb begin
    next_busy_cnt = i_xact_busy ? busy_cnt + 32'h1 : 32'h0;
    next_ovr_seen = ovr_seen;
    if (i_reg_wr.wr && i_reg_wr.addr == GPSW_ADDR_STRAP_OVR) begin
      next_ovr_seen = i_reg_wr.data[GPSW_BIT_OVR];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_cnt <= 32'h0;
      ovr_seen <= GPSW_RST_STRAP_OVR[GPSW_BIT_OVR];
    end else begin
      busy_cnt <= next_busy_cnt;
      ovr_seen <= next_ovr_seen;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  pin_enable_a: assert property (lo_wr ##1 !lo_wr |=>
    o_gp_pin_oe[0] == ($past(i_reg_wr.data[4], 2) &
    ~$past(i_reg_wr.data[5], 2))) else $error("pin 0 drive mismatch");
  idle_low_a: assert property ((o_gp_pin & ~o_gp_pin_oe) == 4'h0)
    else $error("undriven pin shows a value");
  in_out_a: assert property ((o_gp_pin_in & o_gp_pin_oe) == 4'h0)
    else $error("pin both input and output");
  pair_rsvd_a: assert property (pair_rd |=>
    (o_rd_data & ~GPSW_GPIO_PAIR_MASK) == 8'h00)
    else $error("reserved pin bits nonzero");
  strap_rsvd_a: assert property (i_rd_addr == GPSW_ADDR_STRAP_OVR |=>
    o_rd_data[4:0] == 5'h00) else $error("reserved strap bits nonzero");
  unmapped_read_a: assert property ((i_rd_addr < GPSW_ADDR_GPIO_PAIR_HI ||
    i_rd_addr > GPSW_ADDR_WDOG_CTRL) |=> o_rd_data == 8'h00)
    else $error("unmapped read nonzero");
  sleep_sel_a: assert property (
    $past(i_reset_n) && !$past(ovr_seen) |->
    o_strap_eff.output_sleep_state_sel ==
    $past(i_strap.output_sleep_state_sel))
    else $error("sleep select not from pin");
  sleep_hold_a: assert property (
    $past(ovr_seen) && $past(ovr_seen, 2) |->
    $stable(o_strap_eff.output_sleep_state_sel))
    else $error("sleep select moved under override");
  abort_pulse_a: assert property (o_xact_abort |=> !o_xact_abort)
    else $error("abort longer than one cycle");
  abort_late_a: assert property (o_xact_abort |->
    busy_cnt >= WDOG_UNIT_CYC) else $error("abort before one unit");
endmodule
bind gpsw_regs gpsw_regs_monitor #(.WDOG_UNIT_CYC(WDOG_UNIT_CYC))
  gpsw_regs_monitor_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_reg_wr(i_reg_wr), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
  .i_strap(i_strap), .o_strap_eff(o_strap_eff), .i_gp_pin(i_gp_pin),
  .o_gp_pin(o_gp_pin), .o_gp_pin_oe(o_gp_pin_oe),
  .o_gp_pin_in(o_gp_pin_in), .i_xact_busy(i_xact_busy),
  .o_xact_abort(o_xact_abort));

// ===== gpsw_regs_tb.sv
`timescale 1ns/1ps
module gpsw_regs_tb;
  import gpsw_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  gpsw_reg_wr_t i_reg_wr = '0;
  logic [7:0] i_rd_addr = 8'h00;
  logic [7:0] o_rd_data;
  gpsw_strap_t i_strap = '0;
  gpsw_strap_t o_strap_eff;
  logic [3:0] i_gp_pin = 4'hA;
  logic [3:0] o_gp_pin, o_gp_pin_oe, o_gp_pin_in, nb, oe;
  logic i_xact_busy = 1'b0;
  logic o_xact_abort;
  int bad_count = 0, checks = 0, cyc = 0, ab = 0, n;
  gpsw_regs #(.WDOG_UNIT_CYC(4)) gpsw_regs_i (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .i_strap(i_strap), .o_strap_eff(o_strap_eff),
    .i_gp_pin(i_gp_pin), .o_gp_pin(o_gp_pin), .o_gp_pin_oe(o_gp_pin_oe),
    .o_gp_pin_in(o_gp_pin_in), .i_xact_busy(i_xact_busy),
    .o_xact_abort(o_xact_abort));
  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(negedge i_sys_clk) begin
    cyc++;
    if (o_xact_abort === 1'b1) ab++;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // outputs have settled when this returns
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr <= {1'b1, a, d};
    @(negedge i_sys_clk);
    i_reg_wr.wr <= 1'b0;
    @(negedge i_sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_rd_addr <= a;
    @(negedge i_sys_clk);
    chk(o_rd_data, exp);
  endtask
  task automatic busy_for(input int k);
    i_xact_busy <= 1'b1;
    repeat (k) @(negedge i_sys_clk);
    i_xact_busy <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    @(negedge i_sys_clk);
    rd(8'h1D, 8'h33);
    rd(8'h1E, 8'h33);
    rd(8'h1F, 8'h00);
    rd(8'h20, 8'hFE);
    rd(8'h21, 8'h00);
    chk({o_gp_pin_oe, o_gp_pin_in}, 8'h0A);
    $display("test reset values done");
    for (n = 0; n < 8; n++) begin
      nb = {n[2], 1'b1, n[1], n[0]};
      wr(8'h1D, {nb, nb});
      wr(8'h1E, {nb, nb});
      oe = {4{n[0] & ~n[1]}};
      chk({o_gp_pin_oe, o_gp_pin}, {oe, oe & {4{n[2]}}});
      chk({4'h0, o_gp_pin_in}, {4'h0, {4{n[0] & n[1]}} & 4'hA});
      rd(8'h1D, {nb & 4'hB, nb & 4'hB});
    end
    wr(8'h1D, 8'h90);
    wr(8'h1E, 8'h01);
    chk({o_gp_pin_oe, o_gp_pin}, 8'h64);
    $display("test pin control done");
    i_strap <= 2'b11;
    repeat (2) @(negedge i_sys_clk);
    chk({6'h00, o_strap_eff}, 8'h03);
    rd(8'h1F, 8'h20);
    wr(8'h1F, 8'hFF);
    rd(8'h1F, 8'hE0);
    wr(8'h1F, 8'h80);
    chk({6'h00, o_strap_eff}, 8'h01);
    i_strap <= 2'b10;
    repeat (2) @(negedge i_sys_clk);
    chk({6'h00, o_strap_eff}, 8'h01);
    rd(8'h1F, 8'hA0);
    wr(8'h1F, 8'h00);
    chk({6'h00, o_strap_eff}, 8'h02);
    $display("test strap override done");
    wr(8'h20, 8'h04);
    i_xact_busy <= 1'b1;
    n = 0;
    while (o_xact_abort !== 1'b1 && n < 40) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(8'(n >= 8 && n <= 12), 8'h01);
    i_xact_busy <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
    busy_for(6);
    busy_for(6);
    chk(8'(ab), 8'h01);
    wr(8'h20, 8'h05);
    busy_for(40);
    chk(8'(ab), 8'h01);
    rd(8'h20, 8'h05);
    $display("test watchdog done");
    complete_run();
  end
endmodule
